// >>> rtl/smsbt_pkg.sv
package smsbt_pkg;

   // Commands as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_BST = 4'h6;
   localparam logic [3:0] CMD_NOP = 4'h7;

   // Mode word fields
   localparam int         MODE_BL_LSB = 0;
   localparam int         MODE_CL_LSB = 4;
   localparam int         MODE_WB_BIT = 9;
   localparam logic [2:0] BL_FULL     = 3'h7;
   localparam logic [2:0] CL_THREE    = 3'h3;
   localparam logic [11:0] MODE_RST   = 12'h020;

   // Address pin roles
   localparam int ADDR_BANK_BIT = 11;
   localparam int ADDR_ALL_BIT  = 10;

   // Register offsets
   localparam logic [11:0] OFF_MODE = 12'h000;
   localparam logic [11:0] OFF_STAT = 12'h004;

   // Status fields
   localparam int STAT_ACT_LSB = 0;
   localparam int STAT_SUSP    = 2;
   localparam int STAT_BST     = 3;
   localparam int STAT_BWR     = 4;
   localparam int STAT_COL_LSB = 8;

   localparam logic [1:0] OE_OFF = 2'h3;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } smsbt_apb_req_t;

endpackage

// >>> rtl/smsbt_core.sv
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Masked write byte dropped in same cycle
// (RULE2) Byte stays dropped while mask held high
// (RULE3) Byte stored again once mask low
// (RULE4) Upper mask bits 15:8, lower 7:0
// (RULE5) Column counter advances on masked beats
// (RULE6) Single write selected by mode set
// (RULE7) Reads full burst, writes one word
// (RULE8) Same latencies in single write mode
// (RULE9) Activate only idle precharged bank
// (RULE10) Keep bank-to-bank activate spacing
// (RULE11) Precharge before activate time maximum
// (RULE12) Precharge not before activate time minimum
// (RULE13) Column command after activate-to-column delay
// (RULE14) Clock enable fall suspends next edge
// (RULE15) Suspended: inputs ignored, state held
// (RULE16) Clock enable rise resumes next edge
// (RULE17) Wait clock enable recovery before command
// (RULE18) Limit suspend time for refresh
// (RULE19) Address bits 8 and 9 ignored
// (RULE20) Read mask floats byte two cycles later
// (RULE21) Precharge with bit 10 hits both banks
// (RULE22) Clock enable sampled every edge
module smsbt_core (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   // Memory command pins
   input  wire logic                  cke,
   input  wire logic                  cs_n,
   input  wire logic                  ras_n,
   input  wire logic                  cas_n,
   input  wire logic                  we_n,
   input  wire logic [11:0]           addr,
   input  wire logic                  upper_byte_mask,
   input  wire logic                  lower_byte_mask,
   // Data pins
   input  wire logic [15:0]           dq_in,
   output logic      [15:0]           dq_out,
   output logic      [1:0]            dq_oe_n,
   // APB slave
   input  smsbt_pkg::smsbt_apb_req_t  apb_req,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr
);

   typedef struct packed {
      logic             cke;
      logic [11:0]      mode;
      logic [1:0]       act;
      logic [1:0][1:0]  row;
      logic             bst;
      logic             bwr;
      logic             bbank;
      logic             ap;
      logic [7:0]       col;
      logic [8:0]       left;
      logic [1:0]       m1;
      logic [1:0]       rv;
      logic [1:0][15:0] rp;
      logic [15:0]      dq;
      logic [1:0]       oe_n;
      logic             rdy;
      logic             err;
      logic [31:0]      rdata;
      logic [63:0][15:0] mem;
   } smsbt_state_t;

   smsbt_state_t s_q;
   smsbt_state_t s_d;

   logic [3:0]  cmd;
   logic        go;
   logic        gwr;
   logic        gbank;
   logic        gap;
   logic [7:0]  gcol;
   logic [8:0]  grem;
   logic [5:0]  w_idx;
   logic [15:0] wr_old;
   logic        sel;
   logic        last;

   // Codes above three give 256 beats; only code seven selects full page, which runs until stopped
   function automatic logic [8:0] burst_len(input logic [11:0] m);
      case (m[smsbt_pkg::MODE_BL_LSB +: 3])
         3'h0:    burst_len = 9'h001;
         3'h1:    burst_len = 9'h002;
         3'h2:    burst_len = 9'h004;
         3'h3:    burst_len = 9'h008;
         default: burst_len = 9'h100;
      endcase
   endfunction

   // Sequential wrap inside the burst-aligned block
   function automatic logic [7:0] nxt_col(input logic [7:0] c, input logic [11:0] m);
      logic [8:0] w;
      w = burst_len(m) - 9'h001;
      nxt_col = (c & ~w[7:0]) | ((c + 8'h01) & w[7:0]);
   endfunction

   // Storage is a small window; upper row and column bits alias
   function automatic logic [5:0] mem_idx(input logic b, input logic [1:0] r,
                                          input logic [7:0] c);
      mem_idx = {b, r, c[2:0]};
   endfunction

   localparam logic [11:0] OFF_MODE = smsbt_pkg::OFF_MODE;

   always_comb begin
      s_d    = s_q;
      cmd    = cs_n ? smsbt_pkg::CMD_NOP : {1'b0, ras_n, cas_n, we_n};
      go     = s_q.bst;
      gwr    = s_q.bwr;
      gbank  = s_q.bbank;
      gap    = s_q.ap;
      gcol   = s_q.col;
      grem   = s_q.left;
      w_idx  = mem_idx(gbank, s_q.row[gbank], gcol);
      wr_old = s_q.mem[w_idx];
      sel    = s_q.mode[smsbt_pkg::MODE_CL_LSB +: 3] == smsbt_pkg::CL_THREE;
      last   = 1'b0;

      // Sampled on every edge, also while suspended
      s_d.cke = cke; // RULE22

      // APB: one wait state, then answer
      s_d.rdy   = apb_req.psel && apb_req.penable && !s_q.rdy;
      s_d.err   = 1'b0;
      s_d.rdata = 32'h0000_0000;
      if (s_d.rdy) begin
         case (apb_req.paddr)
            smsbt_pkg::OFF_MODE: s_d.rdata = {20'h0_0000, s_q.mode};
            smsbt_pkg::OFF_STAT: s_d.rdata = {16'h0000, s_q.col, 3'h0, s_q.bwr,
                                               s_q.bst, ~s_q.cke, s_q.act};
            default:             s_d.err = 1'b1;
         endcase
      end
      if (apb_req.psel && apb_req.penable && s_q.rdy && apb_req.pwrite &&
          apb_req.paddr == OFF_MODE) begin
         s_d.mode = apb_req.pwdata[11:0];
      end

      // Internal clock runs only when clock enable was high last edge
      if (s_q.cke) begin // RULE14 RULE15 RULE16
         s_d.m1   = {upper_byte_mask, lower_byte_mask};
         s_d.rv   = {s_q.rv[0], 1'b0};
         s_d.rp[1] = s_q.rp[0];
         // Stage picked by CAS latency, output mask two edges behind pin
         s_d.dq   = s_q.rp[sel]; // RULE8
         s_d.oe_n = ~({2{s_q.rv[sel]}} & ~s_q.m1); // RULE20
         case (cmd)
            smsbt_pkg::CMD_ACT: begin
               s_d.act[addr[smsbt_pkg::ADDR_BANK_BIT]] = 1'b1;
               s_d.row[addr[smsbt_pkg::ADDR_BANK_BIT]] = addr[1:0];
            end
            smsbt_pkg::CMD_PRE: begin
               if (addr[smsbt_pkg::ADDR_ALL_BIT]) begin
                  s_d.act = 2'h0; // RULE21
               end else begin
                  s_d.act[addr[smsbt_pkg::ADDR_BANK_BIT]] = 1'b0;
               end
               // Interrupt takes effect at once, no beat here
               if (addr[smsbt_pkg::ADDR_ALL_BIT] ||
                   addr[smsbt_pkg::ADDR_BANK_BIT] == s_q.bbank) begin
                  go      = 1'b0;
                  s_d.bst = 1'b0;
               end
            end
            smsbt_pkg::CMD_BST: begin
               go      = 1'b0;
               s_d.bst = 1'b0;
            end
            smsbt_pkg::CMD_MRS: begin
               s_d.mode = addr; // RULE6
            end
            smsbt_pkg::CMD_RD, smsbt_pkg::CMD_WR: begin
               go    = 1'b1;
               gwr   = cmd == smsbt_pkg::CMD_WR;
               gbank = addr[smsbt_pkg::ADDR_BANK_BIT];
               gap   = addr[smsbt_pkg::ADDR_ALL_BIT];
               gcol  = addr[7:0]; // RULE19
               grem  = (gwr && s_q.mode[smsbt_pkg::MODE_WB_BIT]) ? 9'h001 // RULE7
                                                                : burst_len(s_q.mode);
            end
            default: begin
            end
         endcase
         if (go) begin
            w_idx  = mem_idx(gbank, s_q.row[gbank], gcol);
            wr_old = s_q.mem[w_idx];
            if (gwr) begin
               if (!lower_byte_mask) begin
                  s_d.mem[w_idx][7:0] = dq_in[7:0]; // RULE1 RULE2 RULE3 RULE4
               end
               if (!upper_byte_mask) begin
                  s_d.mem[w_idx][15:8] = dq_in[15:8]; // RULE1 RULE2 RULE3 RULE4
               end
            end else begin
               s_d.rv[0] = 1'b1;
               s_d.rp[0] = s_q.mem[w_idx];
            end
            // Mask never stalls the counter
            s_d.col   = nxt_col(gcol, s_q.mode); // RULE5
            s_d.left  = grem - 9'h001;
            s_d.bwr   = gwr;
            s_d.bbank = gbank;
            s_d.ap    = gap;
            last      = grem == 9'h001 ||
                        (s_q.mode[smsbt_pkg::MODE_BL_LSB +: 3] != smsbt_pkg::BL_FULL &&
                         grem == 9'h000);
            if (s_q.mode[smsbt_pkg::MODE_BL_LSB +: 3] == smsbt_pkg::BL_FULL &&
                !(gwr && s_q.mode[smsbt_pkg::MODE_WB_BIT])) begin
               last = 1'b0;
            end
            s_d.bst = !last; // RULE7
            // Auto-precharge closes the bank after the final beat, except when burst length is full page
            if (last && gap &&
                s_q.mode[smsbt_pkg::MODE_BL_LSB +: 3] != smsbt_pkg::BL_FULL) begin
               s_d.act[gbank] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s_q      <= '0;
         s_q.mode <= smsbt_pkg::MODE_RST;
         s_q.oe_n <= smsbt_pkg::OE_OFF;
      end else begin
         s_q <= s_d;
      end
   end

   assign dq_out  = s_q.dq;
   assign dq_oe_n = s_q.oe_n;
   assign prdata  = s_q.rdata;
   assign pready  = s_q.rdy;
   assign pslverr = s_q.err;

   // Checks follow the internal clock; only the suspend checks look at frozen edges
   wr_mask_lo_a: assert property ( // RULE1
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && go && gwr && lower_byte_mask |=>
      (s_q.mem[$past(w_idx)] & 16'h00FF) == ($past(wr_old) & 16'h00FF))
      else $error("masked lower byte was written");

   wr_store_hi_a: assert property ( // RULE3
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && go && gwr && !upper_byte_mask |=>
      (s_q.mem[$past(w_idx)] & 16'hFF00) == ($past(dq_in) & 16'hFF00))
      else $error("unmasked upper byte not stored");

   col_adv_a: assert property ( // RULE5
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && s_q.bst && cmd == smsbt_pkg::CMD_NOP &&
      (upper_byte_mask || lower_byte_mask) |=> s_q.col != $past(s_q.col))
      else $error("column stalled on masked beat");

   single_wr_a: assert property ( // RULE7
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && cmd == smsbt_pkg::CMD_WR && s_q.mode[smsbt_pkg::MODE_WB_BIT] |=> !s_q.bst)
      else $error("single write mode kept bursting");

   susp_entry_a: assert property ( // RULE14
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && !cke |=> ##1 ($stable(s_q.col) && $stable(s_q.act)))
      else $error("state moved after suspend entry");

   susp_hold_a: assert property ( // RULE15
      @(posedge sys_clk) disable iff (!rst_b)
      !s_q.cke |=> $stable(dq_out) && $stable(dq_oe_n) && $stable(s_q.row))
      else $error("outputs changed while suspended");

   susp_exit_a: assert property ( // RULE16
      @(posedge sys_clk) disable iff (!rst_b)
      !s_q.cke && cke && s_q.bst ##1 cmd == smsbt_pkg::CMD_NOP |=>
      s_q.col != $past(s_q.col))
      else $error("burst did not resume after suspend");

   // Read masking gates only the output enables; data keeps flowing
   rd_mask_lat_a: assert property ( // RULE20
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && upper_byte_mask ##1 s_q.cke |=> dq_oe_n[1])
      else $error("upper byte driven two cycles after mask");

   rd_cl2_a: assert property ( // RULE8
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && cmd == smsbt_pkg::CMD_RD && !lower_byte_mask &&
      s_q.mode[smsbt_pkg::MODE_CL_LSB +: 3] != smsbt_pkg::CL_THREE ##1 s_q.cke |=>
      !dq_oe_n[0])
      else $error("read data missing at latency two");

   pre_all_a: assert property ( // RULE21
      @(posedge sys_clk) disable iff (!rst_b)
      s_q.cke && cmd == smsbt_pkg::CMD_PRE && addr[smsbt_pkg::ADDR_ALL_BIT] |=>
      s_q.act == 2'h0)
      else $error("precharge all left a bank open");

endmodule

// >>> dv/smsbt_host.sv
`timescale 1ns/10ps
module smsbt_host #(
   parameter int T_RAS = 5,
   parameter int T_RP  = 2
) (
   // Clock
   input  wire logic        sys_clk,
   // Command pins
   output logic             cke,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [11:0]      addr,
   // Mask and data pins
   output logic             upper_byte_mask,
   output logic             lower_byte_mask,
   output logic [15:0]      dq_in
);
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n, addr, upper_byte_mask, lower_byte_mask, dq_in} =
         {smsbt_pkg::CMD_NOP, 30'h0000_0000};
   end

   task automatic cmd(input logic [3:0] c, input logic [11:0] a, input logic [15:0] d,
                      input logic [1:0] m);
      @(posedge sys_clk);
      {cs_n, ras_n, cas_n, we_n} <= c;
      addr <= a;
      dq_in <= d;
      {upper_byte_mask, lower_byte_mask} <= m;
   endtask

   // Idle data is inverted so stale write data never looks valid
   task automatic nop(input int n);
      repeat (n) begin
         cmd(smsbt_pkg::CMD_NOP, ~addr, ~dq_in, 2'h0);
      end
   endtask

   task automatic hold_cke(input logic v);
      cke <= v;
   endtask

   // Open-row minimum also covers column and bank-to-bank spacing
   task automatic act(input logic b, input logic [1:0] r);
      cmd(smsbt_pkg::CMD_ACT, {b, 9'h000, r}, ~dq_in, 2'h0);
      nop(T_RAS);
   endtask

   // Runs are far shorter than any open-row or refresh limit
   task automatic pre(input logic [11:0] a);
      cmd(smsbt_pkg::CMD_PRE, a, ~dq_in, 2'h0);
      nop(T_RP);
   endtask
endmodule

// >>> dv/smsbt_core_tb.sv
`timescale 1ns/10ps
module smsbt_core_tb;
   logic                      sys_clk = 1'b0;
   logic                      rst_b = 1'b0;
   smsbt_pkg::smsbt_apb_req_t apb_req = '0;
   logic [31:0]               prdata;
   logic                      pready;
   logic                      pslverr;
   logic [15:0]               dq_out;
   logic [1:0]                dq_oe_n;
   logic                      cke;
   logic                      cs_n;
   logic                      ras_n;
   logic                      cas_n;
   logic                      we_n;
   logic [11:0]               addr;
   logic                      upper_byte_mask;
   logic                      lower_byte_mask;
   logic [15:0]               dq_in;
   logic [15:0]               mem [8];
   logic                      ck1 = 1'b1;
   logic                      ck2 = 1'b1;
   int                        failures = 0;
   int                        check_count = 0;
   int                        cyc = 0;

   always #12.5 sys_clk = ~sys_clk;

   smsbt_core smsbt_core_i (.sys_clk, .rst_b, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
      .upper_byte_mask, .lower_byte_mask, .dq_in, .dq_out, .dq_oe_n, .apb_req, .prdata,
      .pready, .pslverr);
   smsbt_host smsbt_host_i (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
      .upper_byte_mask, .lower_byte_mask, .dq_in);

   task automatic report_and_stop;
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // A beat counts only if the edge that produced it was not frozen
   always @(posedge sys_clk) begin
      ck1 <= cke;
      ck2 <= ck1;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge sys_clk);
      apb_req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
   endtask

   // Always eight beats on the pins; only the first n may land
   task automatic wr_burst(input logic [11:0] a, input logic [15:0] d, input logic [15:0] m,
                           input int n);
      logic [15:0] dd;
      logic [2:0]  c;
      for (int i = 0; i < 8; i++) begin
         dd = d + 16'(i * 257);
         c = a[2:0] + 3'(i);
         smsbt_host_i.cmd(i == 0 ? smsbt_pkg::CMD_WR : smsbt_pkg::CMD_NOP, a, dd, m[2*i+:2]);
         if (i < n && !m[2*i]) mem[c][7:0] = dd[7:0];
         if (i < n && !m[2*i+1]) mem[c][15:8] = dd[15:8];
      end
      smsbt_host_i.nop(2);
   endtask

   // Suspend after beat sus; a precharge-all on frozen edges must be ignored
   task automatic rd_burst(input logic [11:0] a, input int cl, input int sus);
      int got;
      int j;
      int k;
      got = 0;
      j = 0;
      k = 0;
      smsbt_host_i.cmd(smsbt_pkg::CMD_RD, a, dq_in, 2'h0);
      while (got < 8 && j < 40) begin
         if (k > 0 ? k < 4 : got == sus) begin
            k++;
            if (k == 2 || k == 3) smsbt_host_i.cmd(smsbt_pkg::CMD_PRE, 12'h400, dq_in, 2'h3);
            else smsbt_host_i.nop(1);
            smsbt_host_i.hold_cke(k == 4);
         end else smsbt_host_i.nop(1);
         j++;
         if (dq_oe_n === 2'b00 && ck2) begin
            if (got == 0) chk("latency", j, cl + 1);
            chk("read beat", dq_out, mem[got]);
            got++;
         end
      end
      chk("beat count", got, 8);
   endtask

   // Bank one, row two: upper byte masked on a write beat and on a read
   task automatic rd_mask;
      logic [31:0] r;
      logic        e;
      apb(1'b1, 12'h000, 32'h021, r, e);
      smsbt_host_i.act(1'b1, 2'h2);
      smsbt_host_i.cmd(smsbt_pkg::CMD_WR, 12'h800, 16'hA55A, 2'h0);
      smsbt_host_i.cmd(smsbt_pkg::CMD_NOP, 12'h800, 16'h3CC3, 2'h2);
      smsbt_host_i.nop(2);
      smsbt_host_i.cmd(smsbt_pkg::CMD_RD, 12'h800, dq_in, 2'h2);
      smsbt_host_i.nop(3);
      chk("masked oe", dq_oe_n, 32'h2);
      chk("lower beat", dq_out[7:0], 32'h5A);
      smsbt_host_i.nop(1);
      chk("unmasked oe", dq_oe_n, 32'h0);
      chk("half written", dq_out, 32'h00C3);
      smsbt_host_i.nop(1);
      chk("burst end", dq_oe_n, 32'h3);
      smsbt_host_i.pre(12'h800);
   endtask

   initial begin
      logic [31:0] r;
      logic        e;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      smsbt_host_i.nop(2);
      chk("oe reset", dq_oe_n, 2'h3);
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk("mode reset", r, 32'h020);
      apb(1'b0, 12'h008, 32'h0, r, e);
      chk("unmapped", {r[30:0], e}, 32'h1);
      apb(1'b1, 12'h000, 32'h003, r, e);
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk("mode rw", r, 32'h003);
      smsbt_host_i.act(1'b0, 2'h0);
      wr_burst(12'h000, 16'h1234, 16'h0000, 8);
      wr_burst(12'h000, 16'hC0DE, 16'h00E9, 8);
      rd_burst(12'h000, 2, 8);
      smsbt_host_i.cmd(smsbt_pkg::CMD_MRS, 12'h233, dq_in, 2'h0);
      smsbt_host_i.nop(2);
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk("mode by pins", r, 32'h233);
      wr_burst(12'h304, 16'h5A5A, 16'h0000, 1);
      apb(1'b0, 12'h004, 32'h0, r, e);
      chk("single write", r[15:3], {8'h05, 5'h02});
      rd_burst(12'h000, 3, 2);
      smsbt_host_i.act(1'b1, 2'h0);
      apb(1'b0, 12'h004, 32'h0, r, e);
      chk("banks open", r[3:0], 4'h3);
      smsbt_host_i.pre(12'h400);
      apb(1'b0, 12'h004, 32'h0, r, e);
      chk("all closed", r[1:0], 2'h0);
      rd_mask();
      report_and_stop();
   end
endmodule
